// [shared/deser_regs_pkg.sv]
// register offsets, field positions, reset values and timing for the misc/status/gpio slice
// assumes an 8-bit register port and a 100 MHz system clock
package deser_regs_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_SCRATCH_B = 8'h19;
  localparam logic [7:0] ADDR_GPIO_CFG  = 8'h1a;
  localparam logic [7:0] ADDR_FREQ      = 8'h1b;
  localparam logic [7:0] ADDR_STATUS    = 8'h1c;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] SCRATCH_RESET  = 8'h01;
  localparam logic [7:0] GPIO_CFG_RESET = 8'h00;
  localparam logic [7:0] FREQ_RESET     = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int GLB_LEVEL_BIT     = 7;
  localparam int GLB_DIR_BIT       = 5;
  localparam int GLB_EN_BIT        = 4;
  localparam int P9_LEVEL_BIT      = 3;
  localparam int P9_DIR_BIT        = 1;
  localparam int P9_EN_BIT         = 0;
  localparam int ST_TWO_CH_BIT     = 4;
  localparam int ST_AUDIO_LOCK_BIT = 3;
  localparam int ST_CDR_LOCK_BIT   = 0;
  // reserved status bit 5 reads one
  localparam logic [7:0] ST_FIXED_ONES = 8'h20;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int OSC_PERIOD_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_DIV_RAW   = (OSC_PERIOD_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int OSC_DIV_CYC   = (OSC_DIV_RAW < 1) ? 1 : OSC_DIV_RAW;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // ************************************************************
  // pad modes
  // ************************************************************
  typedef enum logic [1:0] {
    PAD_FUNC_OUT,
    PAD_TRI,
    PAD_GPIO_OUT,
    PAD_GPIO_IN
  } pad_mode_t;

  // decode a {dir, en} pair
  function automatic pad_mode_t decode_pair(input logic dir, input logic en);
    pad_mode_t m;
    case ({dir, en})
      2'b00:   m = PAD_FUNC_OUT;
      2'b10:   m = PAD_TRI;
      2'b01:   m = PAD_GPIO_OUT;
      default: m = PAD_GPIO_IN;
    endcase
    return m;
  endfunction

endpackage

// [design/pixel_freq_counter.sv]
// pixel clock edge counter over an interval of oscillator periods
// assumes pixel clock is sampled as a synchronous input
`timescale 1ns/1ps
module pixel_freq_counter
  import deser_regs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // control
  input  wire logic       start_i,
  input  wire logic [7:0] interval_i,
  // pixel clock sample
  input  wire logic       pclk_i,
  // result
  output logic      [7:0] count_o,
  output logic            busy_o
);
  localparam int DIVW = $clog2(OSC_DIV_CYC + 1);
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(OSC_DIV_CYC - 1);

  logic            pclk_prev_reg;
  logic [DIVW-1:0] div_reg;
  logic [7:0]      remain_reg;
  logic            pclk_rise;

  assign pclk_rise = pclk_i & ~pclk_prev_reg;

  // ************************************************************
  // pixel edge detect
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pclk_prev_reg <= 1'b0;
    end else begin
      pclk_prev_reg <= pclk_i;
    end
  end

  // ************************************************************
  // interval timing
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_reg    <= '0;
      remain_reg <= 8'h00;
      busy_o     <= 1'b0;
    end else if (start_i) begin
      div_reg    <= '0;
      remain_reg <= interval_i;
      busy_o     <= (interval_i != 8'h00);
    end else if (busy_o) begin
      if (div_reg == DIV_LAST) begin
        div_reg    <= '0;
        remain_reg <= remain_reg - 8'h01;
        if (remain_reg == 8'h01) begin
          busy_o <= 1'b0;
        end
      end else begin
        div_reg <= div_reg + DIVW'(1);
      end
    end
  end

  // ************************************************************
  // edge count
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_o <= FREQ_RESET;
    end else if (start_i) begin
      count_o <= 8'h00;
    end else if (busy_o && pclk_rise && count_o != COUNT_MAX) begin
      count_o <= count_o + 8'h01;
    end
  end

  sat_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (count_o == COUNT_MAX && !start_i) |=> count_o == COUNT_MAX)
    else $error("edge count left saturation");

  idle_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!busy_o && !start_i) |=> $stable(count_o))
    else $error("edge count changed outside interval");

endmodule

// [design/deser_misc_status_gpio_regs.sv]
// misc register slice: scratch byte, global/pin-nine gpio config, frequency counter, status
// assumes register port accesses are single-cycle strobes, pins synchronous to CLK_SYS_I
`timescale 1ns/1ps
module deser_misc_status_gpio_regs
  import deser_regs_pkg::*;
#(
  parameter int NUM_PINS = 4
) (
  // clock and reset
  input  wire logic                CLK_SYS_I,
  input  wire logic                SRST_I,
  // register port
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  input  wire logic [7:0]          REG_ADDR_I,
  input  wire logic [7:0]          REG_WDATA_I,
  output logic      [7:0]          REG_RDATA_O,
  output logic                     REG_RVALID_O,
  // pixel clock sample
  input  wire logic                PCLK_I,
  // pin nine pad
  input  wire logic                GPIO9_FUNC_I,
  input  wire logic                GPIO9_REMOTE_EN_I,
  input  wire logic                GPIO9_REMOTE_VAL_I,
  input  wire logic                GPIO9_I,
  output logic                     GPIO9_O,
  output logic                     GPIO9_OE_O,
  output logic                     GPIO9_IN_O,
  // other pads under global force
  input  wire logic [NUM_PINS-1:0] PIN_DIR_I,
  input  wire logic [NUM_PINS-1:0] PIN_EN_I,
  input  wire logic [NUM_PINS-1:0] PIN_LEVEL_I,
  input  wire logic [NUM_PINS-1:0] PIN_FUNC_I,
  output logic      [NUM_PINS-1:0] PIN_O,
  output logic      [NUM_PINS-1:0] PIN_OE_O,
  // receiver state
  input  wire logic                TWO_CH_RX_I,
  input  wire logic                AUDIO_PLL_LOCK_I,
  input  wire logic                CDR_LOCK_CH0_I,
  input  wire logic                CDR_LOCK_CH1_I
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0] scratch_reg;
  logic [7:0] gpio_cfg_reg;
  logic [7:0] status_reg;
  logic [7:0] freq_count;
  logic       freq_busy;
  logic       freq_start;
  logic       wr_scratch;
  logic       wr_gpio_cfg;
  logic       lock_next;
  logic [1:0] pin9_drive;
  logic [1:0] pin_drive [NUM_PINS];
  logic       glb_level;
  logic       p9_level;
  logic       p9_gpio_val;
  pad_mode_t  glb_mode;
  pad_mode_t  p9_mode;

  assign wr_scratch  = REG_WR_I && (REG_ADDR_I == ADDR_SCRATCH_B);
  assign wr_gpio_cfg = REG_WR_I && (REG_ADDR_I == ADDR_GPIO_CFG);
  assign freq_start  = REG_WR_I && (REG_ADDR_I == ADDR_FREQ);

  assign glb_level   = gpio_cfg_reg[GLB_LEVEL_BIT];
  assign p9_level    = gpio_cfg_reg[P9_LEVEL_BIT];
  assign glb_mode    = decode_pair(gpio_cfg_reg[GLB_DIR_BIT], gpio_cfg_reg[GLB_EN_BIT]);
  assign p9_mode     = decode_pair(gpio_cfg_reg[P9_DIR_BIT], gpio_cfg_reg[P9_EN_BIT]);
  // remote control replaces the local level
  assign p9_gpio_val = GPIO9_REMOTE_EN_I ? GPIO9_REMOTE_VAL_I : p9_level;

  // resolve one pad into {oe, out}
  function automatic logic [1:0] pad_drive(input pad_mode_t ind,
                                           input pad_mode_t glb,
                                           input logic      func,
                                           input logic      gpio_val,
                                           input logic      glb_val);
    pad_mode_t mode;
    logic      val;
    // individual setting wins unless it is plain functional
    mode = (ind != PAD_FUNC_OUT) ? ind : glb;
    val  = (ind != PAD_FUNC_OUT) ? gpio_val : glb_val;
    case (mode)
      PAD_FUNC_OUT: pad_drive = {1'b1, func};
      PAD_TRI:      pad_drive = 2'b00;
      PAD_GPIO_OUT: pad_drive = {1'b1, val};
      PAD_GPIO_IN:  pad_drive = 2'b00;
      default:      pad_drive = 2'b00;
    endcase
  endfunction

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      scratch_reg <= SCRATCH_RESET;
    end else if (wr_scratch) begin
      scratch_reg <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      gpio_cfg_reg <= GPIO_CFG_RESET;
    end else if (wr_gpio_cfg) begin
      gpio_cfg_reg <= REG_WDATA_I;
    end
  end

  // ************************************************************
  // frequency counter
  // ************************************************************
  pixel_freq_counter u_freq (
    .clk_i      (CLK_SYS_I),
    .srst_i     (SRST_I),
    .start_i    (freq_start),
    .interval_i (REG_WDATA_I),
    .pclk_i     (PCLK_I),
    .count_o    (freq_count),
    .busy_o     (freq_busy)
  );

  // ************************************************************
  // status
  // ************************************************************
  assign lock_next = TWO_CH_RX_I ? (CDR_LOCK_CH0_I & CDR_LOCK_CH1_I) : CDR_LOCK_CH0_I;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg                    <= 8'h00;
      status_reg[ST_TWO_CH_BIT]     <= TWO_CH_RX_I;
      status_reg[ST_AUDIO_LOCK_BIT] <= AUDIO_PLL_LOCK_I;
      status_reg[ST_CDR_LOCK_BIT]   <= lock_next;
    end
  end

  // ************************************************************
  // register reads
  // ************************************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      REG_RDATA_O  <= 8'h00;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          ADDR_SCRATCH_B: REG_RDATA_O <= scratch_reg;
          ADDR_GPIO_CFG:  REG_RDATA_O <= gpio_cfg_reg;
          ADDR_FREQ:      REG_RDATA_O <= freq_count;
          ADDR_STATUS:    REG_RDATA_O <= status_reg | ST_FIXED_ONES;
          default:        REG_RDATA_O <= 8'h00;
        endcase
      end
    end
  end

  // ************************************************************
  // pads
  // ************************************************************
  assign pin9_drive = pad_drive(p9_mode, glb_mode, GPIO9_FUNC_I, p9_gpio_val, glb_level);

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      GPIO9_O    <= 1'b0;
      GPIO9_OE_O <= 1'b0;
      GPIO9_IN_O <= 1'b0;
    end else begin
      GPIO9_OE_O <= pin9_drive[1];
      GPIO9_O    <= pin9_drive[0];
      GPIO9_IN_O <= GPIO9_I;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_drive[i] = pad_drive(decode_pair(PIN_DIR_I[i], PIN_EN_I[i]), glb_mode,
                               PIN_FUNC_I[i], PIN_LEVEL_I[i], glb_level);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      PIN_O    <= '0;
      PIN_OE_O <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        PIN_OE_O[i] <= pin_drive[i][1];
        PIN_O[i]    <= pin_drive[i][0];
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  scratch_read_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (wr_scratch ##1 (REG_RD_I && REG_ADDR_I == ADDR_SCRATCH_B && !REG_WR_I))
      |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
    else $error("scratch byte did not read back");

  global_level_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (!PIN_DIR_I[0] && !PIN_EN_I[0] && glb_mode == PAD_GPIO_OUT)
      |=> (PIN_OE_O[0] && PIN_O[0] == $past(glb_level)))
    else $error("global level not driven");

  global_tri_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (!PIN_DIR_I[0] && !PIN_EN_I[0] && (glb_mode == PAD_TRI || glb_mode == PAD_GPIO_IN))
      |=> !PIN_OE_O[0])
    else $error("pad driven in global tri-state or input");

  own_wins_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (PIN_DIR_I[1] && !PIN_EN_I[1]) |=> !PIN_OE_O[1])
    else $error("global force overrode own tri-state");

  pin9_level_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (p9_mode == PAD_GPIO_OUT && !GPIO9_REMOTE_EN_I)
      |=> (GPIO9_OE_O && GPIO9_O == $past(p9_level)))
    else $error("pin nine level not driven");

  pin9_input_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (p9_mode == PAD_GPIO_IN) |=> !GPIO9_OE_O)
    else $error("pin nine driven in input mode");

  freq_start_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (freq_start && REG_WDATA_I != 8'h00) |=> (freq_count == 8'h00 && freq_busy))
    else $error("counter did not restart");

  freq_span_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (freq_start && REG_WDATA_I == 8'h01) ##1 (!freq_start)[*4] |=> !freq_busy)
    else $error("interval length wrong");

  lock_dual_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (TWO_CH_RX_I && !CDR_LOCK_CH1_I) |=> !status_reg[ST_CDR_LOCK_BIT])
    else $error("lock shown with one channel unlocked");

  status_bits_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    ##1 (status_reg[ST_AUDIO_LOCK_BIT] == $past(AUDIO_PLL_LOCK_I)
         && status_reg[ST_TWO_CH_BIT] == $past(TWO_CH_RX_I)))
    else $error("status bits do not follow receiver");

endmodule

// [tb/host_model.sv]
// host on the register port: strobed single-byte writes and reads
// assumes strobes are driven at the falling edge and the answer comes one cycle later
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       clk_i,
  // register port
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // data is taken only when the valid pulse is seen
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask

  // write then read the same address in the very next cycle
  task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    q = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
endmodule

// [tb/test_deser_misc_status_gpio_regs.sv]
// self-checking bench for the misc register slice
// assumes the host model drives the register port; pixel clock toggles every cycle
`timescale 1ns/1ps
module test_deser_misc_status_gpio_regs;
  import deser_regs_pkg::*;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       wr, rd, rvalid, pclk = 1'b0;
  logic [7:0] addr, wdata, rdata, cfg, rdv;
  logic       g9_func = 1'b0, g9_rem_en = 1'b0, g9_rem_val = 1'b0, g9_in = 1'b1;
  logic       g9_o, g9_oe, g9_in_o;
  logic [3:0] p_dir = 4'h0, p_en = 4'h0, p_lvl = 4'h0, p_func = 4'h5, p_o, p_oe;
  logic       two_ch = 1'b0, aud = 1'b0, lk0 = 1'b0, lk1 = 1'b0;
  int         fail_count = 0;
  int         total_checks = 0;
  int         cycles = 0;

  always #5 clk = ~clk;
  always @(negedge clk) pclk <= ~pclk;

  deser_misc_status_gpio_regs #(.NUM_PINS(4)) i_deser_misc_status_gpio_regs (
    .CLK_SYS_I(clk), .SRST_I(srst), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .PCLK_I(pclk),
    .GPIO9_FUNC_I(g9_func), .GPIO9_REMOTE_EN_I(g9_rem_en), .GPIO9_REMOTE_VAL_I(g9_rem_val),
    .GPIO9_I(g9_in), .GPIO9_O(g9_o), .GPIO9_OE_O(g9_oe), .GPIO9_IN_O(g9_in_o),
    .PIN_DIR_I(p_dir), .PIN_EN_I(p_en), .PIN_LEVEL_I(p_lvl), .PIN_FUNC_I(p_func),
    .PIN_O(p_o), .PIN_OE_O(p_oe), .TWO_CH_RX_I(two_ch), .AUDIO_PLL_LOCK_I(aud),
    .CDR_LOCK_CH0_I(lk0), .CDR_LOCK_CH1_I(lk1));

  host_model i_host_model (
    .clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata), .rvalid_i(rvalid));

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    i_host_model.rd_reg(a, d);
    chk(name, exp, d);
  endtask

  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      close_out();
    end
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    rd_chk(ADDR_SCRATCH_B, 8'h01, "scratch_rst");
    rd_chk(ADDR_GPIO_CFG, 8'h00, "cfg_rst");
    rd_chk(ADDR_FREQ, 8'h00, "freq_rst");
    rd_chk(ADDR_STATUS, 8'h20, "status_rst");
    i_host_model.wr_rd_reg(ADDR_SCRATCH_B, 8'h5a, rdv);
    chk("scratch_wr_rd", 8'h5a, rdv);
    i_host_model.wr_reg(ADDR_SCRATCH_B, 8'ha5);
    i_host_model.wr_reg(8'h40, 8'h3c);
    i_host_model.wr_reg(ADDR_STATUS, 8'hff);
    rd_chk(ADDR_SCRATCH_B, 8'ha5, "scratch_rw");
    rd_chk(8'h40, 8'h00, "unmapped");
    rd_chk(ADDR_STATUS, 8'h20, "status_ro");
    // status inputs: dual mode with one channel locked, then both
    two_ch = 1'b1;
    aud = 1'b1;
    lk0 = 1'b1;
    repeat (2) @(negedge clk);
    rd_chk(ADDR_STATUS, 8'h38, "status_one_ch");
    lk1 = 1'b1;
    repeat (2) @(negedge clk);
    rd_chk(ADDR_STATUS, 8'h39, "status_both");
    two_ch = 1'b0;
    aud = 1'b0;
    lk1 = 1'b0;
    repeat (2) @(negedge clk);
    rd_chk(ADDR_STATUS, 8'h21, "status_single");
    // every global and pin nine pair, levels set to one
    for (int i = 0; i < 4; i++) begin
      cfg = {1'b1, 1'b0, i[1], i[0], 1'b1, 1'b0, i[1], i[0]};
      i_host_model.wr_reg(ADDR_GPIO_CFG, cfg);
      g9_in = i[0];
      repeat (2) @(negedge clk);
      chk("g9_oe", {7'h00, ~i[1]}, {7'h00, g9_oe});
      chk("pin_oe", {4'h0, {4{~i[1]}}}, {4'h0, p_oe});
      chk("g9_in", {7'h00, i[0]}, {7'h00, g9_in_o});
      if (!i[1]) begin
        chk("g9_o", {7'h00, i[0]}, {7'h00, g9_o});
        chk("pin_o", i[0] ? 8'h0f : 8'h05, {4'h0, p_o});
      end
      rd_chk(ADDR_GPIO_CFG, cfg, "cfg_rw");
    end
    // individual pairs win over the global force
    i_host_model.wr_reg(ADDR_GPIO_CFG, 8'h90);
    p_en = 4'b0001;
    p_dir = 4'b0010;
    repeat (2) @(negedge clk);
    chk("pin_oe_ind", 8'h0d, {4'h0, p_oe});
    chk("pin_o_ind", 8'h0c, {4'h0, p_o & 4'b1101});
    // remote control takes pin nine away from the local level
    i_host_model.wr_reg(ADDR_GPIO_CFG, 8'h09);
    g9_rem_en = 1'b1;
    repeat (2) @(negedge clk);
    chk("g9_remote", 8'h00, {7'h00, g9_o});
    g9_rem_en = 1'b0;
    repeat (2) @(negedge clk);
    chk("g9_local", 8'h01, {7'h00, g9_o});
    // frequency counter: one rising edge every two cycles
    i_host_model.wr_reg(ADDR_FREQ, 8'h03);
    repeat (20) @(negedge clk);
    rd_chk(ADDR_FREQ, 8'h06, "freq_3");
    i_host_model.wr_reg(ADDR_FREQ, 8'h80);
    repeat (20) @(negedge clk);
    i_host_model.wr_reg(ADDR_FREQ, 8'h02);
    repeat (16) @(negedge clk);
    rd_chk(ADDR_FREQ, 8'h04, "freq_restart");
    i_host_model.wr_reg(ADDR_FREQ, 8'h7f);
    repeat (520) @(negedge clk);
    rd_chk(ADDR_FREQ, 8'hfe, "freq_7f");
    i_host_model.wr_reg(ADDR_FREQ, 8'h80);
    repeat (530) @(negedge clk);
    rd_chk(ADDR_FREQ, 8'hff, "freq_sat");
    i_host_model.wr_reg(ADDR_FREQ, 8'h00);
    repeat (4) @(negedge clk);
    rd_chk(ADDR_FREQ, 8'h00, "freq_zero");
    // one oscillator period: four cycles, two pixel edges
    i_host_model.wr_reg(ADDR_FREQ, 8'h01);
    repeat (8) @(negedge clk);
    rd_chk(ADDR_FREQ, 8'h02, "freq_1");
    // reset in mid-run brings back the reset values
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rd_chk(ADDR_FREQ, 8'h00, "freq_after_rst");
    rd_chk(ADDR_SCRATCH_B, 8'h01, "scratch_after_rst");
    close_out();
  end
endmodule
